// ==== dv/free_running_timer_tb.sv ====
// self-checking bench for the free-running timer: bus tasks and directed sequences
// assumes the timer header on the include path and the checker compiled before this file
`timescale 1ns/1ns
`default_nettype none
`include "timer_params.svh"
module free_running_timer_tb;
    logic        clk_in;
    logic        reset_n_in;
    logic [3:0]  avs_address_in;
    logic        avs_read_in;
    logic        avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        ext_clock_in;
    logic        halt_in;
    logic        irq_mask_in;
    logic        timer_irq_out;
    logic        pin1;
    logic        pin1_oe;
    logic        pin2;
    logic        pin2_oe;
    int          n_fail;
    int          checks_done;
    logic [7:0]  q;
    // reset view of the map, the last word is unmapped
    logic [7:0]  reset_map [12] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hfc, 8'hff, 8'hfc, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00};
    // divider codes (/4, /2, /8) and the low byte expected 96 cycles after a load
    logic [7:0]  div_code [3] = '{8'h00, 8'h04, 8'h08};
    logic [7:0]  div_low  [3] = '{8'h14, 8'h2c, 8'h08};

    free_running_timer free_running_timer_inst (
        .clk_in                   (clk_in),
        .reset_n_in               (reset_n_in),
        .avs_address_in           (avs_address_in),
        .avs_read_in              (avs_read_in),
        .avs_write_in             (avs_write_in),
        .avs_writedata_in         (avs_writedata_in),
        .avs_readdata_out         (avs_readdata_out),
        .avs_waitrequest_out      (avs_waitrequest_out),
        .ext_clock_in             (ext_clock_in),
        .halt_in                  (halt_in),
        .irq_mask_in              (irq_mask_in),
        .timer_irq_out            (timer_irq_out),
        .match_output_pin1_out    (pin1),
        .match_output_pin1_oe_out (pin1_oe),
        .match_output_pin2_out    (pin2),
        .match_output_pin2_oe_out (pin2_oe)
    );

    // 100 mhz clock
    always #5 clk_in = ~clk_in;

    // range compare; an unknown never passes
    task automatic check(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        checks_done++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic bit_is(input logic b, input logic e);
        check({7'h0, b}, {7'h0, e}, {7'h0, e});
    endtask

    // one avalon transfer: hold everything until waitrequest is seen low
    task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_address_in   <= a;
        avs_writedata_in <= {24'h0, d};
        avs_read_in      <= !w;
        avs_write_in     <= w;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 20);
        r = avs_readdata_out[7:0];
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            $display("mismatch at %0t: bus answer missing", $time);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        acc(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [3:0] a);
        acc(a, 1'b0, 8'h00, q);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi);
        rd(a);
        check(q, lo, hi);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard, far beyond the fewer than a thousand cycles the sequence needs
    initial begin
        cyc(20000);
        n_fail++;
        wrap_up();
    end

    initial begin
        clk_in           = 1'b0;
        reset_n_in       = 1'b0;
        avs_address_in   = 4'h0;
        avs_read_in      = 1'b0;
        avs_write_in     = 1'b0;
        avs_writedata_in = 32'h0;
        ext_clock_in     = 1'b0;
        halt_in          = 1'b1;
        irq_mask_in      = 1'b1;
        n_fail           = 0;
        checks_done      = 0;
        cyc(8);
        reset_n_in <= 1'b1;
        // halted from reset, so the count is still exact
        for (int i = 0; i < 12; i++) begin
            rdchk(i[3:0], reset_map[i], reset_map[i]);
        end
        // latch, run past the wrap, re-read high, then finish the pair
        rdchk(`ADDR_COUNT_HIGH, 8'hff, 8'hff);
        halt_in <= 1'b0;
        cyc(60);
        rdchk(`ADDR_COUNT_HIGH, 8'h00, 8'h00);
        rdchk(`ADDR_COUNT_LOW, 8'hfc, 8'hfc);
        rdchk(`ADDR_COUNT_LOW, 8'h0c, 8'h12);
        rdchk(`ADDR_STATUS, 8'h20, 8'h20);
        rdchk(`ADDR_MIRROR_LOW, 8'h0c, 8'h18);
        rdchk(`ADDR_STATUS, 8'h20, 8'h20);
        // wrap interrupt held pending by the mask, then clear the flag
        wr(`ADDR_CONTROL_ONE, 8'h20);
        cyc(3);
        bit_is(timer_irq_out, 1'b0);
        irq_mask_in <= 1'b0;
        cyc(3);
        bit_is(timer_irq_out, 1'b1);
        rdchk(`ADDR_STATUS, 8'h20, 8'h20);
        rd(`ADDR_COUNT_LOW);
        rdchk(`ADDR_STATUS, 8'h00, 8'h00);
        cyc(3);
        bit_is(timer_irq_out, 1'b0);
        // each internal divider from a fresh load; halt freezes the pair read
        for (int i = 0; i < 3; i++) begin
            halt_in <= 1'b1;
            wr(`ADDR_CONTROL_TWO, div_code[i]);
            wr(`ADDR_COUNT_LOW, 8'h00);
            halt_in <= 1'b0;
            cyc(96);
            halt_in <= 1'b1;
            rdchk(`ADDR_COUNT_HIGH, 8'h00, 8'h00);
            rdchk(`ADDR_COUNT_LOW, div_low[i] - 8'h01, div_low[i] + 8'h01);
        end
        // external clock: eight slow rising edges give exactly eight steps
        wr(`ADDR_CONTROL_TWO, 8'h0c);
        wr(`ADDR_COUNT_LOW, 8'h00);
        halt_in <= 1'b0;
        repeat (8) begin
            cyc(5);
            ext_clock_in <= 1'b1;
            cyc(5);
            ext_clock_in <= 1'b0;
        end
        cyc(10);
        halt_in <= 1'b1;
        rdchk(`ADDR_COUNT_HIGH, 8'h00, 8'h00);
        rdchk(`ADDR_COUNT_LOW, 8'h04, 8'h04);
        // channel one fires at 0010 on /2; channel two left inhibited by a lone high write
        wr(`ADDR_CONTROL_ONE, 8'h41);
        wr(`ADDR_CONTROL_TWO, 8'h84);
        wr(`ADDR_MATCH1_HIGH, 8'h00);
        wr(`ADDR_MATCH1_LOW, 8'h10);
        wr(`ADDR_MATCH2_HIGH, 8'h00);
        wr(`ADDR_MATCH2_LOW, 8'h10);
        wr(`ADDR_MATCH2_HIGH, 8'h00);
        wr(`ADDR_COUNT_LOW, 8'h00);
        halt_in <= 1'b0;
        // two looks one count apart, so a late match is caught
        cyc(42);
        bit_is(pin1, 1'b0);
        cyc(2);
        bit_is(pin1, 1'b1);
        cyc(2);
        halt_in <= 1'b1;
        check({6'h0, pin1_oe, pin1}, 8'h03, 8'h03);
        bit_is(timer_irq_out, 1'b1);
        rd(`ADDR_STATUS);
        check(q & 8'h48, 8'h40, 8'h40);
        rdchk(`ADDR_MATCH1_LOW, 8'h10, 8'h10);
        rd(`ADDR_STATUS);
        check(q & 8'h40, 8'h00, 8'h00);
        cyc(3);
        bit_is(timer_irq_out, 1'b0);
        // force level zero onto the set pin: no flag and no interrupt
        wr(`ADDR_CONTROL_ONE, 8'h48);
        cyc(3);
        bit_is(pin1, 1'b0);
        bit_is(timer_irq_out, 1'b0);
        rd(`ADDR_STATUS);
        check(q & 8'h40, 8'h00, 8'h00);
        check({6'h0, pin2_oe, pin2}, 8'h00, 8'h00);
        // on /4 the same value matches one count later
        wr(`ADDR_CONTROL_ONE, 8'h41);
        wr(`ADDR_CONTROL_TWO, 8'h80);
        wr(`ADDR_COUNT_LOW, 8'h00);
        halt_in <= 1'b0;
        cyc(87);
        bit_is(pin1, 1'b0);
        cyc(4);
        bit_is(pin1, 1'b1);
        // reset while halted: pin low, count back at the reset value
        halt_in    <= 1'b1;
        reset_n_in <= 1'b0;
        cyc(2);
        reset_n_in <= 1'b1;
        bit_is(pin1, 1'b0);
        rdchk(`ADDR_COUNT_HIGH, 8'hff, 8'hff);
        rdchk(`ADDR_COUNT_LOW, 8'hfc, 8'hfc);
        wrap_up();
    end
endmodule

bind free_running_timer timer_sva timer_sva_inst (
    .clk_in                   (clk_in),
    .reset_n_in               (reset_n_in),
    .avs_read_in              (avs_read_in),
    .avs_write_in             (avs_write_in),
    .avs_readdata_out         (avs_readdata_out),
    .avs_waitrequest_out      (avs_waitrequest_out),
    .irq_mask_in              (irq_mask_in),
    .timer_irq_out            (timer_irq_out),
    .match_output_pin1_out    (match_output_pin1_out),
    .match_output_pin1_oe_out (match_output_pin1_oe_out),
    .match_output_pin2_out    (match_output_pin2_out),
    .match_output_pin2_oe_out (match_output_pin2_oe_out)
);
`default_nettype wire

// ==== dv/timer_sva.sv ====
// concurrent checks on the timer's bus answer, interrupt and compare pins
// assumes it is bound onto free_running_timer and that everything runs on clk_in
`timescale 1ns/1ns
`default_nettype none
module timer_sva (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        irq_mask_in,
    input wire logic        timer_irq_out,
    input wire logic        match_output_pin1_out,
    input wire logic        match_output_pin1_oe_out,
    input wire logic        match_output_pin2_out,
    input wire logic        match_output_pin2_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // the answer is a single low cycle, so a held request is never taken twice
    a_answer_one_cycle: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    a_answer_has_cause: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
        else $error("answer without a request");
    a_request_answered: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |-> ##[0:2] !avs_waitrequest_out)
        else $error("request left unanswered");
    // byte registers: upper lanes stay clear and the answer holds past its cycle
    a_readdata_clean: assert property (avs_readdata_out[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    a_readdata_holds: assert property (!avs_waitrequest_out |=> $stable(avs_readdata_out))
        else $error("read data changed after the answer");
    // irq is registered, so the mask of the previous cycle governs it
    a_irq_masked: assert property ($past(irq_mask_in) |-> !timer_irq_out)
        else $error("interrupt raised while masked");
    // a disabled pin never shows the programmed level
    a_pin1_disabled_low: assert property (!match_output_pin1_oe_out |-> !match_output_pin1_out)
        else $error("pin one driven while disabled");
    a_pin2_disabled_low: assert property (!match_output_pin2_oe_out |-> !match_output_pin2_out)
        else $error("pin two driven while disabled");
endmodule
`default_nettype wire

// ==== hdl/free_running_timer.sv ====
// free-running 16-bit timer with prescaler, byte latch and two compare channels
// assumes an avalon-mm master on clk_in and a cpu that drives halt and its interrupt mask
`timescale 1ns/1ns
`default_nettype none
`include "timer_params.svh"
module free_running_timer (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        ext_clock_in,
    input  wire logic        halt_in,
    input  wire logic        irq_mask_in,
    output logic             timer_irq_out,
    output logic             match_output_pin1_out,
    output logic             match_output_pin1_oe_out,
    output logic             match_output_pin2_out,
    output logic             match_output_pin2_oe_out
);
    timer_pkg::bus_state_e bus_state;
    timer_pkg::count_t     count;
    logic [7:0]  timer_control_one;
    logic [7:0]  timer_control_two;
    logic [7:0]  low_latch;
    logic        latch_full;
    logic        wrap_flag;
    logic        wrap_armed;
    logic [2:0]  prescale;
    logic [2:0]  ext_sync;
    logic        ext_prev;
    logic        tick;
    logic        rd_go;
    logic        wr_go;
    logic        status_seen;
    logic [1:0]  clock_divider_select;
    logic [1:0]  match_flag;
    logic [1:0]  pin_level;
    logic [15:0] match_value1;
    logic [15:0] match_value2;
    logic [7:0]  wbyte;
    logic [7:0]  next_readdata;
    logic [1:0]  force_pulse;
    logic        count_low_access;

    assign wbyte                = avs_writedata_in[7:0];
    assign clock_divider_select = timer_control_two[`C2_DIV_HI:`C2_DIV_LO];
    // each request is acted on once, in the cycle the slave accepts it
    assign rd_go                = avs_read_in && bus_state == timer_pkg::bus_idle;
    assign wr_go                = avs_write_in && bus_state == timer_pkg::bus_idle;
    assign status_seen          = rd_go && avs_address_in == `ADDR_STATUS;
    assign count_low_access     = (rd_go || wr_go) && avs_address_in == `ADDR_COUNT_LOW;

    // one wait state: accept in idle, answer next cycle, then one idle cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_state           <= timer_pkg::bus_idle;
            avs_waitrequest_out <= 1'b1;
        end else begin
            unique case (bus_state)
                timer_pkg::bus_idle: begin
                    if (avs_read_in || avs_write_in) begin
                        bus_state           <= timer_pkg::bus_ack;
                        avs_waitrequest_out <= 1'b0;
                    end
                end
                timer_pkg::bus_ack: begin
                    bus_state           <= timer_pkg::bus_done;
                    avs_waitrequest_out <= 1'b1;
                end
                timer_pkg::bus_done: begin
                    bus_state <= timer_pkg::bus_idle;
                end
            endcase
        end
    end

    // read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        next_readdata = 8'h00;
        unique case (avs_address_in)
            `ADDR_CONTROL_ONE: next_readdata = timer_control_one;
            `ADDR_CONTROL_TWO: next_readdata = timer_control_two;
            `ADDR_STATUS: begin
                next_readdata[`ST_MATCH1] = match_flag[0];
                next_readdata[`ST_WRAP]   = wrap_flag;
                next_readdata[`ST_MATCH2] = match_flag[1];
            end
            `ADDR_COUNT_HIGH,
            `ADDR_MIRROR_HIGH: next_readdata = count[15:8];
            `ADDR_COUNT_LOW,
            `ADDR_MIRROR_LOW: next_readdata = latch_full ? low_latch : count[7:0];
            `ADDR_MATCH1_HIGH: next_readdata = match_value1[15:8];
            `ADDR_MATCH1_LOW: next_readdata = match_value1[7:0];
            `ADDR_MATCH2_HIGH: next_readdata = match_value2[15:8];
            `ADDR_MATCH2_LOW: next_readdata = match_value2[7:0];
            default: next_readdata = 8'h00;
        endcase
    end

    // read data captured at acceptance, held through the answer cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (rd_go) begin
            avs_readdata_out <= {24'h00_0000, next_readdata};
        end
    end

    // control registers; force bits act as a pulse on the rising write
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            timer_control_one <= 8'h00;
            timer_control_two <= 8'h00;
            force_pulse       <= 2'b00;
        end else begin
            force_pulse <= 2'b00;
            if (wr_go && avs_address_in == `ADDR_CONTROL_ONE) begin
                timer_control_one <= wbyte & `CONTROL_ONE_MASK;
                force_pulse       <= {wbyte[`C1_FORCE2], wbyte[`C1_FORCE1]};
            end
            if (wr_go && avs_address_in == `ADDR_CONTROL_TWO) begin
                timer_control_two <= wbyte & `CONTROL_TWO_MASK;
            end
        end
    end

    // external clock: three stages, a rising edge counts once stages two and three agree
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ext_sync <= 3'b000;
            ext_prev <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_clock_in};
            if (ext_sync[1] == ext_sync[2]) begin
                ext_prev <= ext_sync[2];
            end
        end
    end

    // prescaler; halt freezes it with the counter, wait has no effect here
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prescale <= 3'h0;
        end else if (wr_go && (avs_address_in == `ADDR_COUNT_LOW || avs_address_in == `ADDR_MIRROR_LOW)) begin
            prescale <= 3'h0;
        end else if (!halt_in) begin
            prescale <= prescale + 3'h1;
        end
    end

    // tick selection by divider code; code 11 runs from the external pin
    always_comb begin
        tick = 1'b0;
        unique case (clock_divider_select)
            `DIV_SEL_BY2: tick = (prescale & `PRESCALE_MASK_BY2) == `PRESCALE_MASK_BY2;
            `DIV_SEL_BY4: tick = (prescale & `PRESCALE_MASK_BY4) == `PRESCALE_MASK_BY4;
            `DIV_SEL_BY8: tick = prescale == `PRESCALE_MASK_BY8;
            `DIV_SEL_EXT: tick = ext_sync[1] == ext_sync[2] && ext_sync[2] && !ext_prev;
        endcase
        tick = tick && !halt_in;
    end

    // counter; either low byte write reloads the only reload value
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count <= `COUNT_RESET;
        end else if (wr_go && (avs_address_in == `ADDR_COUNT_LOW || avs_address_in == `ADDR_MIRROR_LOW)) begin
            count <= `COUNT_RESET;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    // low byte latch, filled by the first high read and held until a low read
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            latch_full <= 1'b0;
            low_latch  <= 8'h00;
        end else if (rd_go && (avs_address_in == `ADDR_COUNT_HIGH || avs_address_in == `ADDR_MIRROR_HIGH)) begin
            if (!latch_full) begin
                low_latch  <= count[7:0];
                latch_full <= 1'b1;
            end
        end else if (rd_go && (avs_address_in == `ADDR_COUNT_LOW || avs_address_in == `ADDR_MIRROR_LOW)) begin
            latch_full <= 1'b0;
        end
    end

    // wrap flag; mirror accesses never reach the clear path
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wrap_flag  <= 1'b0;
            wrap_armed <= 1'b0;
        end else begin
            if (tick && count == 16'hffff) begin
                wrap_flag <= 1'b1;
            end else if (wrap_armed && count_low_access) begin
                wrap_flag <= 1'b0;
            end
            if (status_seen && wrap_flag) begin
                wrap_armed <= 1'b1;
            end else if (count_low_access || !wrap_flag) begin
                wrap_armed <= 1'b0;
            end
        end
    end

    // shared interrupt; it stays pending in the flags while masked
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            timer_irq_out <= 1'b0;
        end else begin
            timer_irq_out <= !irq_mask_in &&
                ((wrap_flag && timer_control_one[`C1_WRAP_IRQ_EN]) ||
                 ((|match_flag) && timer_control_one[`C1_MATCH_IRQ_EN]));
        end
    end

    match_channel u_ch1 (
        .clk_in          (clk_in),
        .reset_n_in      (reset_n_in),
        .write_high_in   (wr_go && avs_address_in == `ADDR_MATCH1_HIGH),
        .write_low_in    (wr_go && avs_address_in == `ADDR_MATCH1_LOW),
        .access_low_in   ((rd_go || wr_go) && avs_address_in == `ADDR_MATCH1_LOW),
        .wdata_in        (wbyte),
        .count_in        (count),
        .tick_in         (tick),
        .plus_one_in     (clock_divider_select != `DIV_SEL_BY2),
        .status_seen_in  (status_seen),
        .level_in        (timer_control_one[`C1_LEVEL1]),
        .force_in        (force_pulse[0]),
        .match_value_out (match_value1),
        .match_flag_out  (match_flag[0]),
        .pin_level_out   (pin_level[0])
    );

    match_channel u_ch2 (
        .clk_in          (clk_in),
        .reset_n_in      (reset_n_in),
        .write_high_in   (wr_go && avs_address_in == `ADDR_MATCH2_HIGH),
        .write_low_in    (wr_go && avs_address_in == `ADDR_MATCH2_LOW),
        .access_low_in   ((rd_go || wr_go) && avs_address_in == `ADDR_MATCH2_LOW),
        .wdata_in        (wbyte),
        .count_in        (count),
        .tick_in         (tick),
        .plus_one_in     (clock_divider_select != `DIV_SEL_BY2),
        .status_seen_in  (status_seen),
        .level_in        (timer_control_one[`C1_LEVEL2]),
        .force_in        (force_pulse[1]),
        .match_value_out (match_value2),
        .match_flag_out  (match_flag[1]),
        .pin_level_out   (pin_level[1])
    );

    // pins registered; with the enable clear the pin is left to general i/o
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            match_output_pin1_out    <= 1'b0;
            match_output_pin2_out    <= 1'b0;
            match_output_pin1_oe_out <= 1'b0;
            match_output_pin2_oe_out <= 1'b0;
        end else begin
            match_output_pin1_out    <= pin_level[0] && timer_control_two[`C2_PIN1_EN];
            match_output_pin2_out    <= pin_level[1] && timer_control_two[`C2_PIN2_EN];
            match_output_pin1_oe_out <= timer_control_two[`C2_PIN1_EN];
            match_output_pin2_oe_out <= timer_control_two[`C2_PIN2_EN];
        end
    end
endmodule
`default_nettype wire

// ==== hdl/match_channel.sv ====
// one output compare channel: value register, inhibit, flag, pin latch
// assumes the parent decodes bus strobes and gives one-cycle tick pulses
`timescale 1ns/1ns
`default_nettype none
`include "timer_params.svh"
module match_channel (
    input  wire logic            clk_in,
    input  wire logic            reset_n_in,
    input  wire logic            write_high_in,
    input  wire logic            write_low_in,
    input  wire logic            access_low_in,
    input  wire logic [7:0]      wdata_in,
    input  wire timer_pkg::count_t count_in,
    input  wire logic            tick_in,
    input  wire logic            plus_one_in,
    input  wire logic            status_seen_in,
    input  wire logic            level_in,
    input  wire logic            force_in,
    output timer_pkg::count_t    match_value_out,
    output logic                 match_flag_out,
    output logic                 pin_level_out
);
    logic inhibit;
    logic armed;
    logic hit;

    // match is sampled on the tick so it fires once per count value
    assign hit = tick_in && !inhibit &&
                 (count_in == (plus_one_in ? match_value_out + 16'h0001 : match_value_out));

    // value registers: only software touches them
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            match_value_out <= `MATCH_RESET;
        end else if (write_high_in) begin
            match_value_out[15:8] <= wdata_in;
        end else if (write_low_in) begin
            match_value_out[7:0] <= wdata_in;
        end
    end

    // high write blocks compares until the low half arrives
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            inhibit <= 1'b0;
        end else if (write_high_in) begin
            inhibit <= 1'b1;
        end else if (write_low_in) begin
            inhibit <= 1'b0;
        end
    end

    // flag: set wins over the second clearing step
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            match_flag_out <= 1'b0;
            armed          <= 1'b0;
        end else begin
            if (hit) begin
                match_flag_out <= 1'b1;
            end else if (armed && access_low_in) begin
                match_flag_out <= 1'b0;
            end
            if (status_seen_in && match_flag_out) begin
                armed <= 1'b1;
            end else if (access_low_in || !match_flag_out) begin
                armed <= 1'b0;
            end
        end
    end

    // pin latch; forcing copies the level without touching the flag
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_level_out <= 1'b0;
        end else if (hit || force_in) begin
            pin_level_out <= level_in;
        end
    end
endmodule
`default_nettype wire

// ==== inc/timer_params.svh ====
// constants for the free-running timer with two output compare channels
// assumes an 8-bit register space behind an avalon-mm slave, one word per register
// How it works
// - 16-bit up-counter read as two bytes
// - mirror view never clears the wrap flag
// - low byte write or reset loads fffc
// - counter steps at cpu/2, /4, /8 or external
// - divider codes: 00 /4, 01 /2, 10 /8
// - high byte read latches the low byte
// - latched low byte held until low read
// - lone low read returns live count
// - wrap to zero sets wrap flag
// - wrap interrupt when enabled and unmasked
// - wrap clear: status read, then low access
// - counting continues in wait mode
// - halt freezes counter, reset restarts it
// - two 16-bit compare values checked each tick
// - compare values software only, reset 8000
// - match sets flag, drives level, pin low in reset
// - match interrupt when enabled and unmasked
// - match clear: status read, then value low access
// - high write inhibits matches until low write
// - /2 matches at value, others value plus one
// - pin disabled: no drive, match still works
// - force copies level, no flag, no irq
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
`define ADDR_CONTROL_ONE     4'h0
`define ADDR_CONTROL_TWO     4'h1
`define ADDR_STATUS          4'h2
`define ADDR_COUNT_HIGH      4'h3
`define ADDR_COUNT_LOW       4'h4
`define ADDR_MIRROR_HIGH     4'h5
`define ADDR_MIRROR_LOW      4'h6
`define ADDR_MATCH1_HIGH     4'h7
`define ADDR_MATCH1_LOW      4'h8
`define ADDR_MATCH2_HIGH     4'h9
`define ADDR_MATCH2_LOW      4'ha
`define COUNT_RESET          16'hfffc
`define MATCH_RESET          16'h8000
`define DIV_SEL_BY4          2'h0
`define DIV_SEL_BY2          2'h1
`define DIV_SEL_BY8          2'h2
`define DIV_SEL_EXT          2'h3
`define PRESCALE_MASK_BY2    3'h1
`define PRESCALE_MASK_BY4    3'h3
`define PRESCALE_MASK_BY8    3'h7
`define C1_MATCH_IRQ_EN      6
`define C1_WRAP_IRQ_EN       5
`define C1_FORCE2            4
`define C1_FORCE1            3
`define C1_LEVEL2            2
`define C1_LEVEL1            0
`define C2_PIN1_EN           7
`define C2_PIN2_EN           6
`define C2_DIV_HI            3
`define C2_DIV_LO            2
`define ST_MATCH1            6
`define ST_WRAP              5
`define ST_MATCH2            3
`define CONTROL_ONE_MASK     8'h7d
`define CONTROL_TWO_MASK     8'hcc
`endif

// ==== inc/timer_pkg.sv ====
// types shared by the timer files
// assumes nothing beyond the constants header
package timer_pkg;
    typedef enum logic [2:0] {
        bus_idle  = 3'b001,
        bus_ack   = 3'b010,
        bus_done  = 3'b100
    } bus_state_e;
    typedef logic [15:0] count_t;
endpackage
